/* rtl/pac_pkg.sv */
/*
 * Shared constants and types for the class power measurement register bank.
 * Assumes one 25 MHz clock and a plain byte-wide register port.
 */
package pac_pkg;

   localparam int NUM_PORTS = 4;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int POWER_W = 7;

   // Register offsets.
   localparam logic [7:0] ADDR_MEAS_CTRL = 8'h50;
   localparam logic [7:0] ADDR_PORT1_POWER = 8'h51;
   localparam logic [7:0] ADDR_PORT2_POWER = 8'h52;
   localparam logic [7:0] ADDR_PORT3_POWER = 8'h53;
   localparam logic [7:0] ADDR_PORT4_POWER = 8'h54;
   localparam logic [7:0] ADDR_FOLD_CTRL = 8'h55;
   localparam logic [7:0] ADDR_EVENT_STATUS = 8'h56;
   localparam logic [7:0] ADDR_EVENT_MASK = 8'h57;

   // Field positions.
   localparam int MANUAL_REQ_LSB = 4;
   localparam int AUTO_EN_LSB = 0;
   localparam int FOLD_SEL_LSB = 4;
   localparam int EVT_DETECT_LSB = 4;
   localparam int EVT_MANUAL_DONE_LSB = 0;

   // Reset values.
   localparam logic [7:0] MEAS_CTRL_RESET = 8'h00;
   localparam logic [7:0] POWER_RESET = 8'h00;
   localparam logic [7:0] FOLD_CTRL_RESET = 8'h00;
   localparam logic [7:0] EVENT_STATUS_RESET = 8'h00;
   localparam logic [7:0] EVENT_MASK_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Timing: full-draw settle time after power good, then the cycle count.
   localparam int CLK_KHZ = 25000;
   localparam int FULL_DRAW_MS = 100;
   localparam int FULL_DRAW_CYCLES = FULL_DRAW_MS * CLK_KHZ;

   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_CLASSING,
      SEQ_SETTLE,
      SEQ_DUE
   } pac_seq_state_t;

   typedef enum logic [0:0] {
      MEAS_IDLE,
      MEAS_WAIT
   } pac_meas_state_t;

endpackage

/* rtl/pac_port_seq.sv */
/*
 * Per-port automatic measurement sequencer.
 * Assumes the power-on command is a one-cycle pulse and power good a level, both on i_mclk.
 */
`timescale 1ns/1ps
module pac_port_seq
   import pac_pkg::*;
#(
   parameter int unsigned SETTLE_CYCLES = FULL_DRAW_CYCLES
) (
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_reset,
   // Port events.
   input wire logic i_auto_measure_enable,
   input wire logic i_port_power_on_command,
   input wire logic i_pd_request,
   input wire logic i_power_good,
   input wire logic i_taken,
   // Results.
   output logic o_pd_request_seen,
   output logic o_due
);

   pac_seq_state_t state;
   logic auto_armed;
   logic [31:0] settle_count;

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         state <= SEQ_IDLE;
         auto_armed <= 1'b0;
         settle_count <= 32'h0;
         o_pd_request_seen <= 1'b0;
      end else begin
         o_pd_request_seen <= 1'b0;
         if (i_port_power_on_command) begin
            // The enable is sampled at the command; later changes wait for the next one.
            state <= SEQ_CLASSING;
            auto_armed <= i_auto_measure_enable;
            settle_count <= 32'h0;
         end else begin
            case (state)
               SEQ_CLASSING: begin
                  o_pd_request_seen <= i_pd_request;
                  if (i_power_good) begin
                     state <= auto_armed ? SEQ_SETTLE : SEQ_IDLE;
                     settle_count <= 32'h0;
                  end
               end
               SEQ_SETTLE: begin
                  if (!i_power_good) begin
                     state <= SEQ_IDLE;
                  end else if (settle_count >= SETTLE_CYCLES - 1) begin
                     state <= SEQ_DUE;
                  end else begin
                     settle_count <= settle_count + 32'h1;
                  end
               end
               SEQ_DUE: begin
                  if (i_taken || !i_power_good) begin
                     state <= SEQ_IDLE;
                  end
               end
               default: begin
                  state <= SEQ_IDLE;
               end
            endcase
         end
      end
   end

   assign o_due = (state == SEQ_DUE);

endmodule

/* rtl/pac_measure_regs.sv */
/*
 * Class power measurement control, result and foldback register bank for four ports.
 * Assumes a same-clock measurement unit that answers each start with one done pulse,
 * and a register master that never needs wait states.
 */
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module pac_measure_regs
   import pac_pkg::*;
#(
   parameter int unsigned SETTLE_CYCLES = FULL_DRAW_CYCLES
) (
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_reset,
   // Register port.
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [DATA_W-1:0] o_rdata,
   // Port state from the port controller.
   input wire logic [NUM_PORTS-1:0] i_port_power_on_command,
   input wire logic [NUM_PORTS-1:0] i_pd_request,
   input wire logic [NUM_PORTS-1:0] i_power_good,
   // Power measurement unit.
   output logic o_measure_start,
   output logic [1:0] o_measure_port,
   input wire logic i_measure_done,
   input wire logic [POWER_W-1:0] i_measure_power,
   // Power limit loading.
   output logic [NUM_PORTS-1:0] o_power_cut_limit_load,
   output logic [POWER_W-1:0] o_power_cut_limit_power,
   // Foldback select and interrupt.
   output logic [NUM_PORTS-1:0] o_raised_power_fold_select,
   output logic o_irq
);

   ////////////////////////////////////////////////////////////////////////////////

   function automatic logic [1:0] first_port(input logic [NUM_PORTS-1:0] bits);
      logic [1:0] idx;
      idx = 2'd0;
      for (int i = NUM_PORTS - 1; i >= 0; i--) begin
         if (bits[i]) begin
            idx = 2'(i);
         end
      end
      return idx;
   endfunction

   function automatic logic [NUM_PORTS-1:0] port_bit(input logic [1:0] port);
      return 4'h1 << port;
   endfunction

   // Places a per-port field at its bit position within a register byte, so the
   // layout is fixed by the package constants and not repeated at every use.
   function automatic logic [DATA_W-1:0] place_field(
      input logic [NUM_PORTS-1:0] bits,
      input int lsb
   );
      logic [DATA_W-1:0] word;
      word = '0;
      word[lsb +: NUM_PORTS] = bits;
      return word;
   endfunction

   function automatic logic [DATA_W-1:0] result_byte(input logic [POWER_W-1:0] code);
      return {1'b0, code};
   endfunction

   function automatic logic reg_hit(
      input logic strobe,
      input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] target
   );
      return strobe && (addr == target);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////

   logic [NUM_PORTS-1:0] manual_measure_request;
   logic [NUM_PORTS-1:0] auto_measure_enable;
   logic [NUM_PORTS-1:0] fold_enable;
   logic [NUM_PORTS-1:0] pd_request_seen_flag;
   logic [DATA_W-1:0] event_status;
   logic [DATA_W-1:0] event_mask;
   logic [POWER_W-1:0] measured_power_code [NUM_PORTS];
   pac_meas_state_t meas_state;
   logic cur_manual;
   logic [NUM_PORTS-1:0] auto_due;
   logic [NUM_PORTS-1:0] auto_taken;
   logic [NUM_PORTS-1:0] manual_done;
   logic meas_fire;
   logic wr_ctrl;
   logic wr_fold;
   logic wr_status;
   logic wr_mask;
   logic [DATA_W-1:0] next_event_status;
   logic [DATA_W-1:0] event_set;
   logic [DATA_W-1:0] read_word;
   logic auto_result;

   assign wr_ctrl = reg_hit(i_wr, i_addr, ADDR_MEAS_CTRL);
   assign wr_fold = reg_hit(i_wr, i_addr, ADDR_FOLD_CTRL);
   assign wr_status = reg_hit(i_wr, i_addr, ADDR_EVENT_STATUS);
   assign wr_mask = reg_hit(i_wr, i_addr, ADDR_EVENT_MASK);
   assign meas_fire = (meas_state == MEAS_WAIT) && i_measure_done;
   assign manual_done = (meas_fire && cur_manual) ? port_bit(o_measure_port) : 4'h0;
   // A port that lost power good during its measurement keeps its old limits.
   assign auto_result = meas_fire && !cur_manual && i_power_good[o_measure_port];

   ////////////////////////////////////////////////////////////////////////////////

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      pac_port_seq #(
         .SETTLE_CYCLES(SETTLE_CYCLES)
      ) u_seq (
         .i_mclk(i_mclk),
         .i_reset(i_reset),
         .i_auto_measure_enable(auto_measure_enable[p]),
         .i_port_power_on_command(i_port_power_on_command[p]),
         .i_pd_request(i_pd_request[p]),
         .i_power_good(i_power_good[p]),
         .i_taken(auto_taken[p]),
         .o_pd_request_seen(pd_request_seen_flag[p]),
         .o_due(auto_due[p])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         auto_measure_enable <= MEAS_CTRL_RESET[AUTO_EN_LSB +: NUM_PORTS];
      end else if (wr_ctrl) begin
         auto_measure_enable <= i_wdata[AUTO_EN_LSB +: NUM_PORTS];
      end
   end

   // A write of one in the same cycle as completion keeps the bit set, so a fresh
   // request is never swallowed; the port is then measured again.
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         manual_measure_request <= MEAS_CTRL_RESET[MANUAL_REQ_LSB +: NUM_PORTS];
      end else begin
         manual_measure_request <= (manual_measure_request & ~manual_done)
            | (wr_ctrl ? i_wdata[MANUAL_REQ_LSB +: NUM_PORTS] : 4'h0);
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         fold_enable <= FOLD_CTRL_RESET[FOLD_SEL_LSB +: NUM_PORTS];
      end else if (wr_fold) begin
         fold_enable <= i_wdata[FOLD_SEL_LSB +: NUM_PORTS];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         o_raised_power_fold_select <= 4'h0;
      end else begin
         o_raised_power_fold_select <= fold_enable & i_power_good;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////

   // One measurement engine serves all ports. Manual requests win over automatic
   // ones because software is waiting on them; automatic ones stay due meanwhile.
   always_comb begin
      auto_taken = 4'h0;
      if (meas_state == MEAS_IDLE && manual_measure_request == 4'h0 && auto_due != 4'h0) begin
         auto_taken = port_bit(first_port(auto_due));
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         meas_state <= MEAS_IDLE;
         cur_manual <= 1'b0;
         o_measure_port <= 2'd0;
         o_measure_start <= 1'b0;
      end else begin
         o_measure_start <= 1'b0;
         case (meas_state)
            MEAS_IDLE: begin
               if (manual_measure_request != 4'h0) begin
                  o_measure_port <= first_port(manual_measure_request);
                  cur_manual <= 1'b1;
                  o_measure_start <= 1'b1;
                  meas_state <= MEAS_WAIT;
               end else if (auto_due != 4'h0) begin
                  o_measure_port <= first_port(auto_due);
                  cur_manual <= 1'b0;
                  o_measure_start <= 1'b1;
                  meas_state <= MEAS_WAIT;
               end
            end
            MEAS_WAIT: begin
               if (i_measure_done) begin
                  meas_state <= MEAS_IDLE;
               end
            end
            default: begin
               meas_state <= MEAS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         for (int i = 0; i < NUM_PORTS; i++) begin
            measured_power_code[i] <= POWER_RESET[POWER_W-1:0];
         end
      end else if (meas_fire) begin
         measured_power_code[o_measure_port] <= i_measure_power;
      end
   end

   // Only automatic results reach the limit registers; manual ones leave them to software.
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         o_power_cut_limit_load <= 4'h0;
      end else if (auto_result) begin
         o_power_cut_limit_load <= port_bit(o_measure_port);
      end else begin
         o_power_cut_limit_load <= 4'h0;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         o_power_cut_limit_power <= POWER_RESET[POWER_W-1:0];
      end else if (auto_result) begin
         o_power_cut_limit_power <= i_measure_power;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////

   assign event_set = place_field(pd_request_seen_flag, EVT_DETECT_LSB)
      | place_field(manual_done, EVT_MANUAL_DONE_LSB);

   // Hardware events win over a write-one-to-clear in the same cycle.
   always_comb begin
      next_event_status = event_status;
      if (wr_status) begin
         next_event_status = next_event_status & ~i_wdata;
      end
      next_event_status = next_event_status | event_set;
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         event_status <= EVENT_STATUS_RESET;
      end else begin
         event_status <= next_event_status;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         event_mask <= EVENT_MASK_RESET;
      end else if (wr_mask) begin
         event_mask <= i_wdata;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(next_event_status & event_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////

   always_comb begin
      read_word = UNMAPPED_READ;
      case (i_addr)
         ADDR_MEAS_CTRL: begin
            read_word = place_field(manual_measure_request, MANUAL_REQ_LSB)
               | place_field(auto_measure_enable, AUTO_EN_LSB);
         end
         ADDR_PORT1_POWER: begin
            read_word = result_byte(measured_power_code[0]);
         end
         ADDR_PORT2_POWER: begin
            read_word = result_byte(measured_power_code[1]);
         end
         ADDR_PORT3_POWER: begin
            read_word = result_byte(measured_power_code[2]);
         end
         ADDR_PORT4_POWER: begin
            read_word = result_byte(measured_power_code[3]);
         end
         ADDR_FOLD_CTRL: begin
            read_word = place_field(fold_enable, FOLD_SEL_LSB);
         end
         ADDR_EVENT_STATUS: begin
            read_word = event_status;
         end
         ADDR_EVENT_MASK: begin
            read_word = event_mask;
         end
         default: begin
            read_word = UNMAPPED_READ;
         end
      endcase
   end

   // Read data stand for one cycle only, so a stale byte is never mistaken for a fresh one.
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         o_rdata <= UNMAPPED_READ;
      end else if (i_rd) begin
         o_rdata <= read_word;
      end else begin
         o_rdata <= UNMAPPED_READ;
      end
   end

endmodule

/* verification/pac_regs_chk.sv */
/* Assertion checker for pac_measure_regs.
   Sees only the bank's ports; bound in at the foot of this file. */
`timescale 1ns/1ps
module pac_regs_chk
   import pac_pkg::*;
#(
   parameter int unsigned SETTLE_CYCLES = 10
) (
   // Clock, reset and register port.
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [DATA_W-1:0] o_rdata,
   // Port state and measurement unit.
   input wire logic [NUM_PORTS-1:0] i_port_power_on_command,
   input wire logic [NUM_PORTS-1:0] i_pd_request,
   input wire logic [NUM_PORTS-1:0] i_power_good,
   input wire logic o_measure_start,
   input wire logic [1:0] o_measure_port,
   input wire logic i_measure_done,
   input wire logic [POWER_W-1:0] i_measure_power,
   // Limit load, foldback and interrupt.
   input wire logic [NUM_PORTS-1:0] o_power_cut_limit_load,
   input wire logic [POWER_W-1:0] o_power_cut_limit_power,
   input wire logic [NUM_PORTS-1:0] o_raised_power_fold_select,
   input wire logic o_irq
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_reset);
   ////////////////////////////////////////////////////////////////////////////////
   property p_idle; !i_rd |=> o_rdata == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data not idle");
   property p_bit7; i_rd && i_addr inside {[8'h51:8'h54]} |=> !o_rdata[7]; endproperty
   a_bit7: assert property (p_bit7) else $error("result bit 7 set");
   property p_start;
      i_wr && i_addr == ADDR_MEAS_CTRL && i_wdata[7:4] != 4'h0 |-> ##[2:80] o_measure_start;
   endproperty
   a_start: assert property (p_start) else $error("no start after request");
   property p_pulse; o_measure_start |=> !o_measure_start; endproperty
   a_pulse: assert property (p_pulse) else $error("start too long");
   property p_port; $changed(o_measure_port) |-> o_measure_start; endproperty
   a_port: assert property (p_port) else $error("port moved mid measurement");
   // A limit load must carry exactly the value that the meter just returned.
   property p_load;
      o_power_cut_limit_load != 4'h0 |->
         $past(i_measure_done) && o_power_cut_limit_power == $past(i_measure_power);
   endproperty
   a_load: assert property (p_load) else $error("limit load without result");
   property p_which;
      o_power_cut_limit_load != 4'h0 |-> o_power_cut_limit_load == 4'h1 << $past(o_measure_port);
   endproperty
   a_which: assert property (p_which) else $error("limit load wrong port");
   property p_pg;
      o_power_cut_limit_load != 4'h0 |-> (o_power_cut_limit_load & $past(i_power_good)) != 4'h0;
   endproperty
   a_pg: assert property (p_pg) else $error("limit load without power good");
   property p_fold; (o_raised_power_fold_select & ~$past(i_power_good)) == 4'h0; endproperty
   a_fold: assert property (p_fold) else $error("fold select without power good");
   c_start: cover property (o_measure_start);
   c_load: cover property (o_power_cut_limit_load != 4'h0);
   c_irq: cover property (o_irq);
   c_fold: cover property (o_raised_power_fold_select != 4'h0);
endmodule

bind pac_measure_regs pac_regs_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
   .i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .i_rd(i_rd), .o_rdata(o_rdata), .i_port_power_on_command(i_port_power_on_command),
   .i_pd_request(i_pd_request), .i_power_good(i_power_good), .o_measure_start(o_measure_start),
   .o_measure_port(o_measure_port), .i_measure_done(i_measure_done),
   .i_measure_power(i_measure_power), .o_power_cut_limit_load(o_power_cut_limit_load),
   .o_power_cut_limit_power(o_power_cut_limit_power),
   .o_raised_power_fold_select(o_raised_power_fold_select), .o_irq(o_irq)
);

/* verification/pac_meter_model.sv */
/* Behavioural power meter: one done pulse per start, prompt or slow.
   Assumes the bank never starts a second measurement before the first is done. */
`timescale 1ns/1ps
module pac_meter_model (
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_reset,
   // Control from the bench and the bank.
   input wire logic i_slow,
   input wire logic [6:0] i_power,
   input wire logic i_measure_start,
   // Result.
   output logic o_measure_done,
   output logic [6:0] o_measure_power
);
   int cnt;
   always_ff @(posedge i_mclk) begin
      o_measure_done <= 1'b0;
      // Outside the done cycle the result bus toggles so stale data never looks valid.
      o_measure_power <= ~o_measure_power;
      if (i_reset) begin
         cnt <= 0;
         o_measure_power <= 7'h2a;
      end else if (i_measure_start) begin
         cnt <= i_slow ? 7 : 1;
      end else if (cnt == 1) begin
         o_measure_done <= 1'b1;
         o_measure_power <= i_power;
         cnt <= 0;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule

/* verification/pse_autoclass_power_regs_tb_top.sv */
/* Self-checking bench for pac_measure_regs with a behavioural meter.
   Assumes the bank's settle count is shortened to 10 cycles. */
`timescale 1ns/1ps
module pse_autoclass_power_regs_tb_top;
   logic i_mclk = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0, slow = 1'b0;
   logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, rv;
   logic [3:0] pon = 4'h0, pdr = 4'h0, pg = 4'h0, load, fold, last_load;
   logic start, done, irq;
   logic [1:0] mport;
   logic [6:0] mpow, pwr = 7'h00, lpow, last_pow;
   int n_mismatch = 0, cmp_count = 0, cyc = 0, n_load = 0;
   always #20 i_mclk = ~i_mclk;
   pac_measure_regs #(.SETTLE_CYCLES(10)) dut (
      .i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_port_power_on_command(pon), .i_pd_request(pdr),
      .i_power_good(pg), .o_measure_start(start), .o_measure_port(mport),
      .i_measure_done(done), .i_measure_power(mpow), .o_power_cut_limit_load(load),
      .o_power_cut_limit_power(lpow), .o_raised_power_fold_select(fold), .o_irq(irq));
   pac_meter_model meter (
      .i_mclk(i_mclk), .i_reset(i_reset), .i_slow(slow), .i_power(pwr),
      .i_measure_start(start), .o_measure_done(done), .o_measure_power(mpow));
   ////////////////////////////////////////////////////////////////////////////////
   task tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge i_mclk) begin
      cyc++;
      if (load != 4'h0) begin
         n_load++;
         last_load = load;
         last_pow = lpow;
      end
      if (cyc == 5000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask
   task rd_raw(input logic [7:0] a);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 rv = o_rdata;
   endtask
   task rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
      rd_raw(a);
      chk(what, exp, rv);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_reset;
      for (int a = 'h50; a <= 'h58; a++) rdc("reset value", 8'(a), 8'h00);
   endtask
   task t_manual;
      slow <= 1'b1;
      for (int p = 0; p < 4; p++) begin
         pwr <= 7'(7'h7f - 5 * p);
         wr(8'h50, 8'h10 << p);
         wr(8'h50, 8'h00);
         rdc("request pending", 8'h50, 8'h10 << p);
         for (int k = 0; k < 20 && rv != 8'h00; k++) rd_raw(8'h50);
         chk("request cleared", 8'h00, rv);
         rdc("result", 8'(8'h51 + p), {1'b0, pwr});
      end
      wr(8'h51, 8'hff);
      rdc("read only result", 8'h51, 8'h7f);
      chk("limit loads", 8'h00, 8'(n_load));
      rdc("done status", 8'h56, 8'h0f);
   endtask
   task t_irq;
      wr(8'h57, 8'h02);
      repeat (2) @(posedge i_mclk);
      #1 chk("irq unmasked", 8'h01, {7'h0, irq});
      wr(8'h56, 8'h02);
      repeat (2) @(posedge i_mclk);
      #1 chk("irq cleared", 8'h00, {7'h0, irq});
      rdc("status after clear", 8'h56, 8'h0d);
      rdc("mask", 8'h57, 8'h02);
   endtask
   task t_auto;
      slow <= 1'b0;
      pwr <= 7'h33;
      wr(8'h50, 8'h01);
      @(posedge i_mclk);
      pon <= 4'h1;
      pdr <= 4'h1;
      @(posedge i_mclk);
      pon <= 4'h0;
      repeat (3) @(posedge i_mclk);
      pg <= 4'h1;
      pdr <= 4'h0;
      for (int k = 0; k < 100 && n_load == 0; k++) @(posedge i_mclk);
      #1 chk("load port", 8'h01, {4'h0, last_load});
      chk("load power", 8'h33, {1'b0, last_pow});
      rdc("request seen", 8'h56, 8'h1d);
      rdc("auto enable kept", 8'h50, 8'h01);
   endtask
   task t_powered;
      pwr <= 7'h21;
      wr(8'h50, 8'h11);
      rdc("powered request", 8'h50, 8'h11);
      for (int k = 0; k < 20 && rv != 8'h01; k++) rd_raw(8'h50);
      chk("powered request cleared", 8'h01, rv);
      rdc("powered result", 8'h51, 8'h21);
      chk("no load from manual", 8'h01, 8'(n_load));
      wr(8'h50, 8'h00);
      pon <= 4'h2;
      @(posedge i_mclk);
      pon <= 4'h0;
      pg <= 4'h3;
      repeat (30) @(posedge i_mclk);
      #1 chk("no load with auto off", 8'h01, 8'(n_load));
      rdc("no request seen", 8'h56, 8'h1d);
   endtask
   task t_fold;
      wr(8'h55, 8'hf0);
      pg <= 4'h5;
      repeat (3) @(posedge i_mclk);
      #1 chk("fold on", 8'h05, {4'h0, fold});
      rdc("fold reg", 8'h55, 8'hf0);
      wr(8'h55, 8'h20);
      repeat (3) @(posedge i_mclk);
      #1 chk("fold without power good", 8'h00, {4'h0, fold});
      chk("single auto load", 8'h01, 8'(n_load));
   endtask
   initial begin
      repeat (12) @(posedge i_mclk);
      i_reset <= 1'b0;
      t_reset();
      t_manual();
      t_irq();
      t_auto();
      t_powered();
      t_fold();
      tally_and_finish();
   end
endmodule
